//--- hw/dual_reload_down_timer.sv
// two-channel 16-bit reload down timer with i/o byte register access
`default_nettype none

// What this block does
// - each channel has a 16-bit reload value, low and high bytes read/writable
// - a counter reaching zero reloads from its reload value and keeps counting
// - reaching zero sets the channel timeout flag, bits 7 and 6, read-only
// - flag clears after control read followed by a read of that channel counter
// - interrupt request while flag set and its enable (bits 5, 4) is one
// - bits 3-2 select pin: address, toggle on channel 1 zero, low, high
// - enable bits 1-0 gate counting; a stopped counter holds and is freely accessed
// - reset clears control bits: counters stopped, pin back to address function
// - reset sets counters and reload values to all ones
// - low-then-high byte reads give a consistent value of a running counter
// - selecting low or high sets the timer level at once; selecting toggle keeps the current level
// - enabled counters decrement once every twenty clocks, shared prescaler
// - low byte read captures high byte; next high read returns the capture
module dual_reload_down_timer
    import reload_timer_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    rst_i,
    input  wire io_req_t io_req_i,
    input  wire logic    address_bit_i,
    output logic [7:0]   io_rdata_o,
    output logic [1:0]   irq_o,
    output logic         timer_output_pin_o,
    output logic         shared_address_line_o
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] count_low_ofs(input int n);
        count_low_ofs = (n == 1) ? OFS_COUNT_LOW_CH1 : OFS_COUNT_LOW_CH0;
    endfunction

    function automatic logic [7:0] count_high_ofs(input int n);
        count_high_ofs = (n == 1) ? OFS_COUNT_HIGH_CH1 : OFS_COUNT_HIGH_CH0;
    endfunction

    function automatic logic [7:0] reload_low_ofs(input int n);
        reload_low_ofs = (n == 1) ? OFS_RELOAD_LOW_CH1 : OFS_RELOAD_LOW_CH0;
    endfunction

    function automatic logic [7:0] reload_high_ofs(input int n);
        reload_high_ofs = (n == 1) ? OFS_RELOAD_HIGH_CH1 : OFS_RELOAD_HIGH_CH0;
    endfunction

    timer_control_status_t control;
    timer_control_status_t next_control;
    logic [15:0]           down_count_value [2];
    logic [15:0]           next_count       [2];
    logic [15:0]           reload_value     [2];
    logic [15:0]           next_reload      [2];
    logic [7:0]            high_hold        [2];
    logic [1:0]            hold_valid;
    logic [1:0]            next_hold_valid;
    logic [1:0]            clear_armed;
    logic [1:0]            next_clear_armed;
    logic [PRESCALE_W-1:0] prescale;
    logic                  timer_level;
    logic                  next_timer_level;

    wire       control_sel = (io_req_i.addr == OFS_CONTROL);
    wire       control_wr  = io_req_i.wr && control_sel;
    wire       control_rd  = io_req_i.rd && control_sel;
    wire       tick        = (prescale == PRESCALE_LAST);
    wire [7:0] control_in  = io_req_i.wdata;

    logic [1:0] count_low_sel;
    logic [1:0] count_high_sel;
    logic [1:0] reload_low_sel;
    logic [1:0] reload_high_sel;
    logic [1:0] count_rd;
    logic [1:0] count_wr;
    logic [1:0] enable_now;
    logic [1:0] expire;
    logic [1:0] flag_clear;

    for (genvar n = 0; n < 2; n++)
    begin : g_decode
        assign count_low_sel[n]   = (io_req_i.addr == count_low_ofs(n));
        assign count_high_sel[n]  = (io_req_i.addr == count_high_ofs(n));
        assign reload_low_sel[n]  = (io_req_i.addr == reload_low_ofs(n));
        assign reload_high_sel[n] = (io_req_i.addr == reload_high_ofs(n));
        assign count_rd[n] = io_req_i.rd && (count_low_sel[n] || count_high_sel[n]);
        assign count_wr[n] = io_req_i.wr && (count_low_sel[n] || count_high_sel[n]);
        // an enable written in the tick cycle already counts
        assign enable_now[n] = control.count_enable[n]
                             || (control_wr && control_in[n]);
        // zero is reached on the tick that leaves one; a zero written by
        // software expires on its next tick instead of wrapping
        assign expire[n] = tick && enable_now[n] && !count_wr[n]
                         && (down_count_value[n] == COUNT_ONE
                             || down_count_value[n] == COUNT_ZERO);
        assign flag_clear[n] = clear_armed[n] && count_rd[n];
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0] read_mux;

    always_comb
    begin
        read_mux = RESET_RDATA;
        if (control_sel)
            read_mux = control;
        for (int n = 0; n < 2; n++)
        begin
            if (count_low_sel[n])
                read_mux = down_count_value[n][7:0];
            if (count_high_sel[n])
                read_mux = hold_valid[n] ? high_hold[n]
                                         : down_count_value[n][15:8];
            if (reload_low_sel[n])
                read_mux = reload_value[n][7:0];
            if (reload_high_sel[n])
                read_mux = reload_value[n][15:8];
        end
    end

    // ----------------------------------------------------------------
    // next state of channels and control
    // ----------------------------------------------------------------
    always_comb
    begin
        next_control = control;
        if (control_wr)
        begin
            // flags are read-only, the write reaches bits 5..0 only
            next_control.irq_enable   = control_in[5:4];
            next_control.out_select   = out_select_t'(control_in[3:2]);
            next_control.count_enable = control_in[1:0];
        end
        for (int n = 0; n < 2; n++)
        begin
            // set wins over a clear in the same cycle
            next_control.timeout_flag[n] = expire[n]
                || (control.timeout_flag[n] && !flag_clear[n]);

            if (control_rd && control.timeout_flag[n])
                next_clear_armed[n] = 1'b1;
            else if (flag_clear[n] || !control.timeout_flag[n])
                next_clear_armed[n] = 1'b0;
            else
                next_clear_armed[n] = clear_armed[n];

            next_count[n] = down_count_value[n];
            if (io_req_i.wr && count_low_sel[n])
                next_count[n] = {down_count_value[n][15:8], io_req_i.wdata};
            else if (io_req_i.wr && count_high_sel[n])
                next_count[n] = {io_req_i.wdata, down_count_value[n][7:0]};
            else if (expire[n])
                next_count[n] = reload_value[n];
            else if (tick && enable_now[n])
                next_count[n] = down_count_value[n] - COUNT_ONE;

            next_reload[n] = reload_value[n];
            if (io_req_i.wr && reload_low_sel[n])
                next_reload[n] = {reload_value[n][15:8], io_req_i.wdata};
            else if (io_req_i.wr && reload_high_sel[n])
                next_reload[n] = {io_req_i.wdata, reload_value[n][7:0]};

            if (io_req_i.rd && count_low_sel[n])
                next_hold_valid[n] = 1'b1;
            else if (io_req_i.rd && count_high_sel[n])
                next_hold_valid[n] = 1'b0;
            else
                next_hold_valid[n] = hold_valid[n];
        end
    end

    // ----------------------------------------------------------------
    // timer output level
    // ----------------------------------------------------------------
    always_comb
    begin
        next_timer_level = timer_level;
        if (control_wr && control_in[3:2] == OUT_LOW)
            next_timer_level = 1'b0;
        else if (control_wr && control_in[3:2] == OUT_HIGH)
            next_timer_level = 1'b1;
        else if (expire[1] && next_control.out_select == OUT_TOGGLE)
            next_timer_level = !timer_level;
    end

    assign timer_output_pin_o    = timer_level;
    assign shared_address_line_o = (control.out_select == OUT_ADDRESS)
                                   ? address_bit_i : timer_level;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            control     <= timer_control_status_t'(RESET_CONTROL);
            clear_armed <= '0;
            hold_valid  <= '0;
            prescale    <= PRESCALE_RESET;
            timer_level <= 1'b0;
            io_rdata_o  <= RESET_RDATA;
            irq_o       <= '0;
        end
        else
        begin
            control     <= next_control;
            clear_armed <= next_clear_armed;
            hold_valid  <= next_hold_valid;
            prescale    <= tick ? PRESCALE_RESET : prescale + 1'b1;
            timer_level <= next_timer_level;
            if (io_req_i.rd)
                io_rdata_o <= read_mux;
            irq_o       <= next_control.timeout_flag & next_control.irq_enable;
        end
    end

    for (genvar n = 0; n < 2; n++)
    begin : g_channel
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                down_count_value[n] <= RESET_COUNT;
                reload_value[n]     <= RESET_RELOAD;
                high_hold[n]        <= RESET_COUNT[15:8];
            end
            else
            begin
                down_count_value[n] <= next_count[n];
                reload_value[n]     <= next_reload[n];
                if (io_req_i.rd && count_low_sel[n])
                    high_hold[n] <= down_count_value[n][15:8];
            end
        end
    end

endmodule
`default_nettype wire

//--- include/reload_timer_pkg.sv
// constants, types and register map of the dual reload down timer
`default_nettype none
package reload_timer_pkg;

    // ----------------------------------------------------------------
    // register map, 8-bit i/o addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_COUNT_LOW_CH0   = 8'h0C;
    localparam logic [7:0] OFS_COUNT_HIGH_CH0  = 8'h0D;
    localparam logic [7:0] OFS_RELOAD_LOW_CH0  = 8'h0E;
    localparam logic [7:0] OFS_RELOAD_HIGH_CH0 = 8'h0F;
    localparam logic [7:0] OFS_CONTROL         = 8'h10;
    localparam logic [7:0] OFS_COUNT_LOW_CH1   = 8'h14;
    localparam logic [7:0] OFS_COUNT_HIGH_CH1  = 8'h15;
    localparam logic [7:0] OFS_RELOAD_LOW_CH1  = 8'h16;
    localparam logic [7:0] OFS_RELOAD_HIGH_CH1 = 8'h17;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [15:0] RESET_COUNT   = 16'hFFFF;
    localparam logic [15:0] RESET_RELOAD  = 16'hFFFF;
    localparam logic [7:0]  RESET_CONTROL = 8'h00;
    localparam logic [7:0]  RESET_RDATA   = 8'h00;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;
    localparam logic [15:0] COUNT_ONE     = 16'h0001;
    localparam int          PRESCALE_DIV  = 20;
    localparam int          PRESCALE_W    = $clog2(PRESCALE_DIV);
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST  = PRESCALE_W'(PRESCALE_DIV - 1);
    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = '0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OUT_ADDRESS = 2'b00,
        OUT_TOGGLE  = 2'b01,
        OUT_LOW     = 2'b10,
        OUT_HIGH    = 2'b11
    } out_select_t;

    // bit 7 = timeout_flag_ch1 ... bit 0 = count_enable_ch0
    typedef struct packed {
        logic [1:0]  timeout_flag;
        logic [1:0]  irq_enable;
        out_select_t out_select;
        logic [1:0]  count_enable;
    } timer_control_status_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_t;

endpackage
`default_nettype wire

//--- sim/dual_reload_down_timer_asserts.sv
// port-level assertion checker for the dual reload down timer
`default_nettype none
module dual_reload_down_timer_asserts
    import reload_timer_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire io_req_t    io_req_i,
    input wire logic       address_bit_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic [1:0] irq_o,
    input wire logic       timer_output_pin_o,
    input wire logic       shared_address_line_o
);
    // ------------
    // shadow of the writable control bits
    // ------------
    logic [5:0] ctl;
    wire        ctl_wr = io_req_i.wr && io_req_i.addr == OFS_CONTROL;
    wire        ctl_rd = io_req_i.rd && io_req_i.addr == OFS_CONTROL;
    always_ff @(posedge clk_i)
    begin
        ctl <= rst_i ? 6'h00 : (ctl_wr ? io_req_i.wdata[5:0] : ctl);
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_reset_clears: assert property ($fell(rst_i) |-> irq_o == 2'h0 &&
        io_rdata_o == 8'h00 && shared_address_line_o == address_bit_i)
        else $error("outputs not cleared after reset");
    chk_addr_follow: assert property (ctl[3:2] == 2'h0 |->
        shared_address_line_o == address_bit_i) else $error("pin not address");
    chk_pin_muxed: assert property (ctl[3:2] != 2'h0 |->
        shared_address_line_o == timer_output_pin_o) else $error("pin not timer");
    chk_force_low: assert property (ctl[3:2] == 2'h2 |-> !timer_output_pin_o)
        else $error("timer level not low");
    chk_force_high: assert property (ctl[3:2] == 2'h3 |-> timer_output_pin_o)
        else $error("timer level not high");
    chk_irq_masked: assert property ((irq_o & ~ctl[5:4]) == 2'h0)
        else $error("request while disabled");
    chk_ctl_readback: assert property (ctl_rd |=> io_rdata_o[5:0] == $past(ctl))
        else $error("control readback wrong");
    chk_unmapped_zero: assert property (io_req_i.rd && io_req_i.addr == 8'h20
        |=> io_rdata_o == 8'h00) else $error("unmapped read not zero");
    chk_rdata_holds: assert property (!$past(io_req_i.rd) |-> $stable(io_rdata_o))
        else $error("read data moved");
endmodule
`default_nettype wire

//--- sim/tb_dual_reload_down_timer.sv
// self-checking bench for the dual reload down timer
`default_nettype none
module tb_dual_reload_down_timer
    import reload_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    io_req_t     req = '0;
    logic        abit = 1'b0;
    logic [7:0]  rdata;
    logic [1:0]  irq;
    logic        tpin;
    logic        spin;
    logic [7:0]  d;
    logic [15:0] w;
    int          err_total = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          t0;
    dual_reload_down_timer dut_u (.clk_i, .rst_i, .io_req_i(req), .address_bit_i(abit),
        .io_rdata_o(rdata), .irq_o(irq), .timer_output_pin_o(tpin),
        .shared_address_line_o(spin));
    always #50 clk_i = ~clk_i;
    // ------------
    // shared tasks
    // ------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // tests should finish well inside the three thousand cycles of this watchdog
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        req <= '{1'b0, 1'b1, a, v};
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk_i);
        req.rd <= 1'b0;
        @(negedge clk_i);
        d = rdata;
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    task automatic rd16(input logic [7:0] a);
        rd(a);
        w[7:0] = d;
        rd(a + 8'h01);
        w[15:8] = d;
    endtask
    task automatic wait_irq();
        repeat (200)
            if (irq[0] !== 1'b1) @(negedge clk_i);
        chk("irq0", 16'(irq[0]), 16'h0001);
    endtask
    task automatic wait_pin();
        logic v;
        @(negedge clk_i);
        v = tpin;
        repeat (100)
            if (tpin === v) @(negedge clk_i);
    endtask
    // ------------
    // scenarios
    // ------------
    task automatic t_reset();
        for (int i = 0; i < 8; i++)
        begin
            rd(i < 4 ? 8'h0C + 8'(i) : 8'h10 + 8'(i));
            chk("reset byte", 16'(d), 16'h00FF);
        end
        rd(OFS_CONTROL);
        chk("reset control", 16'(d), 16'(RESET_CONTROL));
        rd(8'h20);
        chk("unmapped", 16'(d), 16'h0000);
        abit <= 1'b1;
        @(negedge clk_i);
        chk("address pin", 16'(spin), 16'h0001);
    endtask
    task automatic t_stopped();
        wr16(OFS_COUNT_LOW_CH0, 16'h1234);
        wr16(OFS_RELOAD_LOW_CH1, 16'hA55A);
        wr(OFS_CONTROL, 8'hC0);
        repeat (45) @(posedge clk_i);
        rd16(OFS_COUNT_LOW_CH0);
        chk("held count", w, 16'h1234);
        rd16(OFS_RELOAD_LOW_CH1);
        chk("reload", w, 16'hA55A);
        rd(OFS_CONTROL);
        chk("flags read-only", 16'(d), 16'h0000);
    endtask
    task automatic t_expire();
        // reload bytes written while stopped, so no reload splits them
        wr16(OFS_RELOAD_LOW_CH0, 16'h0003);
        wr16(OFS_COUNT_LOW_CH0, 16'h0003);
        wr(OFS_CONTROL, 8'h11);
        wait_irq();
        t0 = cyc;
        // rewrite right after expiry, well before the next one
        wr16(OFS_RELOAD_LOW_CH0, 16'h0003);
        rd16(OFS_COUNT_LOW_CH0);
        chk("reloaded", w, 16'h0003);
        chk("unarmed keeps", 16'(irq[0]), 16'h0001);
        rd(OFS_CONTROL);
        chk("flag ch0", 16'(d[7:6]), 16'h0001);
        rd(OFS_COUNT_HIGH_CH0);
        chk("flag cleared", 16'(irq[0]), 16'h0000);
        wait_irq();
        chk("period", 16'(cyc - t0), 16'd60);
        wr(OFS_CONTROL, 8'h01);
        @(negedge clk_i);
        chk("masked", 16'(irq[0]), 16'h0000);
        rd(OFS_CONTROL);
        chk("flag kept", 16'(d[6]), 16'h0001);
    endtask
    task automatic t_output();
        wr16(OFS_RELOAD_LOW_CH1, 16'h0002);
        wr16(OFS_COUNT_LOW_CH1, 16'h0002);
        wr(OFS_CONTROL, 8'h06);
        @(negedge clk_i);
        chk("first level", 16'(spin), 16'h0000);
        chk("first pin", 16'(tpin), 16'h0000);
        wait_pin();
        t0 = cyc;
        wait_pin();
        chk("toggle period", 16'(cyc - t0), 16'd40);
        chk("irq1 masked", 16'(irq[1]), 16'h0000);
        rd(OFS_CONTROL);
        chk("flag ch1", 16'(d[7]), 16'h0001);
        wr(OFS_CONTROL, 8'h28);
        @(negedge clk_i);
        chk("forced low", 16'(spin), 16'h0000);
        chk("irq1 enabled", 16'(irq[1]), 16'h0001);
        wr(OFS_CONTROL, 8'h0C);
        @(negedge clk_i);
        chk("forced high", 16'(spin), 16'h0001);
        chk("pin high", 16'(tpin), 16'h0001);
    endtask
    task automatic t_capture();
        wr16(OFS_COUNT_LOW_CH1, 16'h0101);
        wr(OFS_CONTROL, 8'h02);
        rd(OFS_COUNT_LOW_CH1);
        chk("low near start", 16'(d <= 8'h01), 16'h0001);
        repeat (60) @(posedge clk_i);
        rd(OFS_COUNT_HIGH_CH1);
        chk("captured high", 16'(d), 16'h0001);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_stopped();
        t_expire();
        t_output();
        t_capture();
        give_verdict();
    end
endmodule
bind dual_reload_down_timer dual_reload_down_timer_asserts chk_u (.clk_i, .rst_i, .io_req_i,
    .address_bit_i, .io_rdata_o, .irq_o, .timer_output_pin_o, .shared_address_line_o);
`default_nettype wire
